// ===== hw/eat_pkg.sv
package eat_pkg;
  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;  // enable and mode bits
  localparam logic [7:0]  OFS_RATIO     = 8'h04;  // special-tooth ratio, 8.8 fixed point
  localparam logic [7:0]  OFS_TEETH     = 8'h08;  // regular teeth between special teeth
  localparam logic [7:0]  OFS_LIMIT     = 8'h0C;  // most regular teeth allowed
  localparam logic [7:0]  OFS_CAMCNT    = 8'h10;  // cam edges that form the pattern
  localparam logic [7:0]  OFS_RISE      = 8'h14;  // pulse rising angle
  localparam logic [7:0]  OFS_FALL      = 8'h18;  // pulse falling angle
  localparam logic [7:0]  OFS_DELAY     = 8'h1C;  // pulse falling delay, cycles
  localparam logic [7:0]  OFS_STATUS    = 8'h20;  // errors (write one to clear), flags
  localparam logic [7:0]  OFS_BANK      = 8'h24;  // bank count, read only
  localparam logic [7:0]  OFS_PERIOD    = 8'h28;  // last tooth period, read only
  localparam logic [7:0]  OFS_ANGLE     = 8'h2C;  // current extrapolated angle, read only
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_EN_BIT     = 0;  // tracker enable
  localparam int CTRL_EXTRA_BIT  = 1;  // 1: extra-tooth variant, 0: gap-tooth variant
  localparam int CTRL_PULSE_BIT  = 2;  // pulse output enable
  localparam int CTRL_BYTIME_BIT = 3;  // 1: fall after delay, 0: fall at angle
  localparam int ST_ERR_CNT_BIT  = 0;  // special tooth saw wrong regular count
  localparam int ST_ERR_OVR_BIT  = 1;  // regular count went over limit
  localparam int ST_REF_BIT      = 2;  // main reference has been seen
  localparam int ST_BANK_BIT     = 3;  // bank switch waiting for next special tooth
  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int          PERIOD_W     = 24;
  localparam int          RATIO_FRAC   = 8;
  localparam int          ANGLE_FRAC   = 8;
  localparam int          CNT_W        = 8;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [15:0] RATIO_RST    = 16'h0180;  // 1.5
  localparam logic [7:0]  TEETH_RST    = 8'h3A;
  localparam logic [7:0]  LIMIT_RST    = 8'h3A;
  localparam logic [7:0]  CAMCNT_RST   = 8'h01;
  localparam logic [15:0] ANGLE_RST    = 16'h0000;
  localparam logic [23:0] DELAY_RST    = 24'h00_0001;
endpackage

// ===== hw/eat_pulse_out.sv
`timescale 1ns/100ps
`default_nettype none
module eat_pulse_out (
  input  wire logic        core_clk_i,   // core clock
  input  wire logic        arst_n_i,     // async reset, low
  input  wire logic        ce_i,         // clock enable
  input  wire logic        en_i,         // output enable
  input  wire logic        by_time_i,    // fall by delay
  input  wire logic [15:0] angle_i,      // current angle
  input  wire logic [15:0] rise_i,       // rising angle
  input  wire logic [15:0] fall_i,       // falling angle
  input  wire logic [23:0] delay_i,      // fall delay in cycles
  output logic             pulse_o       // pulse pin
);
  import eat_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic {EAT_IDLE, EAT_HIGH} eat_pulse_e;
  eat_pulse_e  st_q, st_d;     // output state
  logic [23:0] dly_q, dly_d;   // cycles since rising edge
  logic        pin_q, pin_d;   // registered pin

  // next state: the rise waits for an exact angle match, so an angle jumped over
  // (a reference reset) is not made up later
  always_comb begin
    st_d  = st_q;
    dly_d = dly_q;
    pin_d = pin_q;
    case (st_q)
      EAT_IDLE: begin
        if (en_i && angle_i == rise_i) begin
          st_d  = EAT_HIGH;
          dly_d = 24'h00_0001;
          pin_d = 1'b1;
        end
      end
      EAT_HIGH: begin
        dly_d = dly_q + 24'h00_0001;
        if (!en_i) begin
          st_d  = EAT_IDLE;
          pin_d = 1'b0;
        end else if (by_time_i ? (dly_q >= delay_i) : (angle_i == fall_i)) begin
          st_d  = EAT_IDLE;
          pin_d = 1'b0;
        end
      end
      default: begin
        st_d  = EAT_IDLE;
        pin_d = 1'b0;
      end
    endcase
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q  <= EAT_IDLE;
      dly_q <= 24'h00_0000;
      pin_q <= 1'b0;
    end else if (ce_i) begin
      st_q  <= st_d;
      dly_q <= dly_d;
      pin_q <= pin_d;
    end
  end

  assign pulse_o = pin_q;
endmodule
`default_nettype wire

// ===== hw/eat_tracker.sv
// Contract
// - cam pattern increments crank bank count
// - bank switch: next special tooth resets angle
// - angle from tooth count plus extrapolation
// - extrapolation uses last measured tooth period
// - extra-tooth and gap-tooth variants selectable
// - any configured special-tooth count supported
// - gap: special if period exceeds scaled previous
// - extra: special if period below scaled previous
// - pulse rises at programmed angle
// - pulse falls at angle or after delay
// - special tooth checks exact regular count
// - regular tooth checks count within limit
// - failed check raises interrupt request
// - angle resolution finer than tenth degree
`timescale 1ns/100ps
`default_nettype none
module eat_tracker (
  input  wire logic                       core_clk_i,   // 50 MHz core clock
  input  wire logic                       arst_n_i,     // async reset, low
  input  wire logic                       ce_i,         // clock enable
  input  wire logic                       cam_pin_i,    // cam sensor pin
  input  wire logic                       crank_pin_i,  // crank sensor pin
  input  wire logic                       hsel_i,       // ahb slave select
  input  wire logic [eat_pkg::ADDR_W-1:0] haddr_i,      // ahb address
  input  wire logic [1:0]                 htrans_i,     // ahb transfer type
  input  wire logic                       hwrite_i,     // ahb write
  input  wire logic [2:0]                 hsize_i,      // ahb size
  input  wire logic [31:0]                hwdata_i,     // ahb write data
  input  wire logic                       hready_i,     // ahb bus ready
  output logic      [31:0]                hrdata_o,     // ahb read data
  output logic                            hreadyout_o,  // ahb slave ready
  output logic                            hresp_o,      // ahb response
  output logic                            pulse_o,      // extrapolated pulse pin
  output logic                            irq_o         // tooth error request
);
  import eat_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] cam_s_q;     // cam stages
  logic [2:0] crk_s_q;     // crank stages
  logic       cam_lvl_q;   // accepted cam level
  logic       crk_lvl_q;   // accepted crank level
  logic       cam_lvl_d;
  logic       crk_lvl_d;
  logic       cam_rise;    // cam rising edge, one cycle
  logic       crk_rise;    // crank rising edge, one cycle

  // a level counts only once stages two and three agree
  always_comb begin
    cam_lvl_d = (cam_s_q[1] == cam_s_q[2]) ? cam_s_q[2] : cam_lvl_q;
    crk_lvl_d = (crk_s_q[1] == crk_s_q[2]) ? crk_s_q[2] : crk_lvl_q;
    cam_rise  = cam_lvl_d & ~cam_lvl_q;
    crk_rise  = crk_lvl_d & ~crk_lvl_q;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cam_s_q   <= 3'h0;
      crk_s_q   <= 3'h0;
      cam_lvl_q <= 1'b0;
      crk_lvl_q <= 1'b0;
    end else if (ce_i) begin
      cam_s_q   <= {cam_s_q[1:0], cam_pin_i};
      crk_s_q   <= {crk_s_q[1:0], crank_pin_i};
      cam_lvl_q <= cam_lvl_d;
      crk_lvl_q <= crk_lvl_d;
    end
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  logic              wr_q, wr_d;       // write data phase pending
  logic [ADDR_W-1:0] wa_q, wa_d;       // write address
  logic [31:0]       rd_q, rd_d;       // read data
  logic              acc;              // valid address phase
  logic [ADDR_W-1:0] aw;               // word-aligned address

  // config registers
  logic [3:0]          ctrl_q, ctrl_d;       // control bits
  logic [15:0]         ratio_q, ratio_d;     // special-tooth ratio
  logic [CNT_W-1:0]    teeth_q, teeth_d;     // expected regular teeth
  logic [CNT_W-1:0]    limit_q, limit_d;     // regular teeth limit
  logic [CNT_W-1:0]    camcnt_q, camcnt_d;   // cam pattern length
  logic [15:0]         rise_q, rise_d;       // rising angle
  logic [15:0]         fall_q, fall_d;       // falling angle
  logic [23:0]         delay_q, delay_d;     // falling delay
  // tracker state
  logic [1:0]          err_q, err_d;         // sticky error bits
  logic                ref_q, ref_d;         // reference seen
  logic                bpend_q, bpend_d;     // bank switch pending
  logic [CNT_W-1:0]    bank_q, bank_d;       // bank count
  logic [CNT_W-1:0]    camseen_q, camseen_d; // cam edges in pattern
  logic [PERIOD_W-1:0] pcnt_q, pcnt_d;       // cycles since crank edge
  logic [PERIOD_W-1:0] last_q, last_d;       // last tooth period
  logic                hprev_q, hprev_d;     // a period is known
  logic [CNT_W-1:0]    rcnt_q, rcnt_d;       // regular teeth since special
  logic [7:0]          tooth_q, tooth_d;     // tooth index since reference
  logic [ANGLE_FRAC-1:0] frac_q, frac_d;     // fraction of a tooth
  logic [PERIOD_W:0]   dda_q, dda_d;         // extrapolation accumulator

  logic [1:0]                     err_set;   // errors found this cycle
  logic [1:0]                     err_clr;   // software clear
  logic [PERIOD_W+15:0]           prod;      // last period times ratio
  logic [PERIOD_W+15-RATIO_FRAC:0] scaled;   // scaled previous period
  logic                           special;   // this edge is a special tooth
  logic [PERIOD_W:0]              dda_sum;   // accumulator plus step
  logic [CNT_W-1:0]               rcnt_inc;  // regular count plus one

  assign acc = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
  assign aw  = {haddr_i[ADDR_W-1:2], 2'b00};

  // bus phases and register writes; hardware error sets beat software clears
  always_comb begin
    wr_d     = acc & hwrite_i;
    wa_d     = acc ? aw : wa_q;
    rd_d     = rd_q;
    ctrl_d   = ctrl_q;
    ratio_d  = ratio_q;
    teeth_d  = teeth_q;
    limit_d  = limit_q;
    camcnt_d = camcnt_q;
    rise_d   = rise_q;
    fall_d   = fall_q;
    delay_d  = delay_q;
    err_clr  = 2'b00;
    if (wr_q) begin
      case (wa_q)
        OFS_CTRL:   ctrl_d   = hwdata_i[3:0];
        OFS_RATIO:  ratio_d  = hwdata_i[15:0];
        OFS_TEETH:  teeth_d  = hwdata_i[CNT_W-1:0];
        OFS_LIMIT:  limit_d  = hwdata_i[CNT_W-1:0];
        OFS_CAMCNT: camcnt_d = hwdata_i[CNT_W-1:0];
        OFS_RISE:   rise_d   = hwdata_i[15:0];
        OFS_FALL:   fall_d   = hwdata_i[15:0];
        OFS_DELAY:  delay_d  = hwdata_i[23:0];
        OFS_STATUS: err_clr  = hwdata_i[1:0];
        default:    err_clr  = 2'b00;  // unmapped or read-only: ignored
      endcase
    end
    if (acc && !hwrite_i) begin
      case (aw)
        OFS_CTRL:   rd_d = {28'h000_0000, ctrl_q};
        OFS_RATIO:  rd_d = {16'h0000, ratio_q};
        OFS_TEETH:  rd_d = {24'h00_0000, teeth_q};
        OFS_LIMIT:  rd_d = {24'h00_0000, limit_q};
        OFS_CAMCNT: rd_d = {24'h00_0000, camcnt_q};
        OFS_RISE:   rd_d = {16'h0000, rise_q};
        OFS_FALL:   rd_d = {16'h0000, fall_q};
        OFS_DELAY:  rd_d = {8'h00, delay_q};
        OFS_STATUS: rd_d = {28'h000_0000, bpend_q, ref_q, err_q};
        OFS_BANK:   rd_d = {24'h00_0000, bank_q};
        OFS_PERIOD: rd_d = {8'h00, last_q};
        OFS_ANGLE:  rd_d = {16'h0000, tooth_q, frac_q};
        default:    rd_d = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // ****************************************************************
  // tooth tracking
  // ****************************************************************
  // the ratio is read live, so a new value applies at the very next edge
  always_comb begin
    prod      = last_q * ratio_q;
    scaled    = prod[PERIOD_W+15:RATIO_FRAC];
    rcnt_inc  = rcnt_q + 8'h01;
    special   = 1'b0;
    if (hprev_q) begin
      if (ctrl_q[CTRL_EXTRA_BIT]) begin
        special = ({8'h00, pcnt_q} < scaled);
      end else begin
        special = ({8'h00, pcnt_q} > scaled);
      end
    end
    err_set   = 2'b00;
    bpend_d   = bpend_q;
    bank_d    = bank_q;
    camseen_d = camseen_q;
    ref_d     = ref_q;
    pcnt_d    = (&pcnt_q) ? pcnt_q : pcnt_q + 24'h00_0001;
    last_d    = last_q;
    hprev_d   = hprev_q;
    rcnt_d    = rcnt_q;
    tooth_d   = tooth_q;
    frac_d    = frac_q;
    dda_d     = dda_q;
    // extrapolate within the tooth: 256 steps per tooth, so with 60 teeth one
    // step is 0.023 degree; the fraction holds at its top if the engine slows
    dda_sum = dda_q + 25'h000_0100;
    if (hprev_q && !(&frac_q)) begin
      if (dda_sum >= {1'b0, last_q}) begin
        dda_d  = dda_sum - {1'b0, last_q};
        frac_d = frac_q + 8'h01;
      end else begin
        dda_d = dda_sum;
      end
    end
    if (ctrl_q[CTRL_EN_BIT]) begin
      if (cam_rise) begin
        if (camseen_q + 8'h01 >= camcnt_q) begin
          camseen_d = 8'h00;
          bank_d    = bank_q + 8'h01;
          bpend_d   = 1'b1;
        end else begin
          camseen_d = camseen_q + 8'h01;
        end
      end
      if (crk_rise) begin
        pcnt_d  = 24'h00_0001;
        last_d  = pcnt_q;
        hprev_d = 1'b1;
        frac_d  = 8'h00;
        dda_d   = 25'h000_0000;
        tooth_d = tooth_q + 8'h01;
        if (special) begin
          if (rcnt_q != teeth_q) begin
            err_set[ST_ERR_CNT_BIT] = 1'b1;
          end
          rcnt_d = 8'h00;
          if (bpend_q || cam_rise) begin
            tooth_d = 8'h00;
            bpend_d = 1'b0;
            ref_d   = 1'b1;
          end
        end else begin
          if (rcnt_inc > limit_q) begin
            err_set[ST_ERR_OVR_BIT] = 1'b1;
          end
          rcnt_d = (&rcnt_q) ? rcnt_q : rcnt_inc;
        end
      end
    end
    err_d = (err_q & ~err_clr) | err_set;
  end

  // all registers, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q      <= 1'b0;
      wa_q      <= 8'h00;
      rd_q      <= 32'h0000_0000;
      ctrl_q    <= CTRL_RST;
      ratio_q   <= RATIO_RST;
      teeth_q   <= TEETH_RST;
      limit_q   <= LIMIT_RST;
      camcnt_q  <= CAMCNT_RST;
      rise_q    <= ANGLE_RST;
      fall_q    <= ANGLE_RST;
      delay_q   <= DELAY_RST;
      err_q     <= 2'b00;
      ref_q     <= 1'b0;
      bpend_q   <= 1'b0;
      bank_q    <= 8'h00;
      camseen_q <= 8'h00;
      pcnt_q    <= 24'h00_0000;
      last_q    <= 24'h00_0000;
      hprev_q   <= 1'b0;
      rcnt_q    <= 8'h00;
      tooth_q   <= 8'h00;
      frac_q    <= 8'h00;
      dda_q     <= 25'h000_0000;
    end else if (ce_i) begin
      wr_q      <= wr_d;
      wa_q      <= wa_d;
      rd_q      <= rd_d;
      ctrl_q    <= ctrl_d;
      ratio_q   <= ratio_d;
      teeth_q   <= teeth_d;
      limit_q   <= limit_d;
      camcnt_q  <= camcnt_d;
      rise_q    <= rise_d;
      fall_q    <= fall_d;
      delay_q   <= delay_d;
      err_q     <= err_d;
      ref_q     <= ref_d;
      bpend_q   <= bpend_d;
      bank_q    <= bank_d;
      camseen_q <= camseen_d;
      pcnt_q    <= pcnt_d;
      last_q    <= last_d;
      hprev_q   <= hprev_d;
      rcnt_q    <= rcnt_d;
      tooth_q   <= tooth_d;
      frac_q    <= frac_d;
      dda_q     <= dda_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the slave stalls the bus while frozen, so no transfer is lost
  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rd_q;
  assign irq_o       = |err_q;

  eat_pulse_out u_pulse (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .en_i       (ctrl_q[CTRL_PULSE_BIT]),
    .by_time_i  (ctrl_q[CTRL_BYTIME_BIT]),
    .angle_i    ({tooth_q, frac_q}),
    .rise_i     (rise_q),
    .fall_i     (fall_q),
    .delay_i    (delay_q),
    .pulse_o    (pulse_o)
  );
endmodule
`default_nettype wire

// ===== bench/eat_tracker_props.sv
`timescale 1ns/100ps
`default_nettype none
module eat_tracker_props
  import eat_pkg::*;
(
  input wire logic        core_clk_i,  // core clock
  input wire logic        arst_n_i,    // async reset, low
  input wire logic        ce_i,        // clock enable
  input wire logic        crank_pin_i, // crank pin
  input wire logic        hsel_i,      // ahb select
  input wire logic [7:0]  haddr_i,     // ahb address
  input wire logic [1:0]  htrans_i,    // ahb transfer type
  input wire logic        hwrite_i,    // ahb write
  input wire logic [31:0] hwdata_i,    // ahb write data
  input wire logic        hready_i,    // ahb ready
  input wire logic [31:0] hrdata_o,    // read data
  input wire logic        hreadyout_o, // slave ready
  input wire logic        hresp_o,     // response
  input wire logic        pulse_o,     // pulse pin
  input wire logic        irq_o        // error request
);
  // ****
  // shadow of control writes, pin quiet time, pulse width
  // ****
  logic        ap;      // address phase taken
  logic        wr_q;    // write data phase pending
  logic [7:0]  wa_q;    // its address
  logic [3:0]  ctrl_q;  // control shadow
  logic [23:0] dly_q;   // delay shadow
  logic [3:0]  quiet_q; // cycles since crank change
  logic        crk_q;   // crank last cycle
  logic [23:0] hi_q;    // cycles pulse has been high
  assign ap = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && ce_i;
  // frozen with ce low, like the block itself
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q    <= 1'b0;
      wa_q    <= 8'h00;
      ctrl_q  <= CTRL_RST;
      dly_q   <= DELAY_RST;
      quiet_q <= 4'h0;
      crk_q   <= 1'b0;
      hi_q    <= 24'h00_0000;
    end else if (ce_i) begin
      wr_q  <= ap && hwrite_i;
      wa_q  <= haddr_i;
      crk_q <= crank_pin_i;
      hi_q  <= pulse_o ? hi_q + 24'h00_0001 : 24'h00_0000;
      if (wr_q && wa_q == OFS_CTRL) ctrl_q <= hwdata_i[3:0];
      if (wr_q && wa_q == OFS_DELAY) dly_q <= hwdata_i[23:0];
      // saturate so a long quiet wheel cannot wrap back to small values
      if (crank_pin_i != crk_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****
  // properties
  // ****
  a_ready_ce: assert property (hreadyout_o == ce_i) else $error("hreadyout differs from ce");
  a_resp_okay: assert property (!hresp_o) else $error("response not okay");
  a_rdata_hold: assert property (!(ap && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (ap && !hwrite_i && haddr_i >= 8'h30 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_back: assert property (ap && !hwrite_i && haddr_i == OFS_CTRL && !wr_q
    |=> hrdata_o[3:0] == ctrl_q) else $error("control readback wrong");
  a_irq_hold: assert property (irq_o && !(wr_q && wa_q == OFS_STATUS) |=> irq_o)
    else $error("request dropped without a status write");
  a_irq_cause: assert property ($rose(irq_o) |-> quiet_q <= 4'd12)
    else $error("request raised away from a tooth");
  a_pulse_off: assert property (!ctrl_q[CTRL_PULSE_BIT] [*3] |-> !pulse_o)
    else $error("pulse high while disabled");
  a_pulse_delay: assert property (ctrl_q[CTRL_BYTIME_BIT] && pulse_o
    |-> {1'b0, hi_q} <= {1'b0, dly_q} + 25'd1) else $error("pulse outlived its delay");
endmodule
bind eat_tracker eat_tracker_props eat_tracker_props_i (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .crank_pin_i(crank_pin_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pulse_o(pulse_o), .irq_o(irq_o));
`default_nettype wire

// ===== bench/eat_wheel_model.sv
`timescale 1ns/100ps
`default_nettype none
module eat_wheel_model (
  input  wire logic        core_clk_i, // clock
  input  wire logic        arst_n_i,   // async reset, low
  input  wire logic        run_i,      // wheel turning
  input  wire logic        extra_i,    // 1: extra tooth, 0: missing tooth
  input  wire logic [7:0]  teeth_i,    // regular spacings per turn, plus one
  input  wire logic [15:0] per_i,      // tooth spacing, cycles
  output logic             cam_o,      // cam sensor
  output logic             crank_o,    // crank sensor
  output logic [7:0]       idx_o       // tooth last passed, 0 = special
);
  // ****
  // wheel
  // ****
  logic [15:0] cnt_q; // cycles since last tooth
  logic [15:0] sp;    // spacing after this tooth
  logic [7:0]  top;   // highest tooth index
  // missing tooth doubles one gap; extra tooth halves the two around it
  always_comb begin
    top = extra_i ? teeth_i : teeth_i - 8'h01;
    sp  = per_i;
    if (!extra_i && idx_o == top) sp = per_i << 1;
    if (extra_i && (idx_o == 8'h00 || idx_o == top)) sp = per_i >> 1;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 16'h0000;
      idx_o <= 8'h00;
    end else if (!run_i) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= sp - 16'h0001) begin
      cnt_q <= 16'h0000;
      idx_o <= (idx_o == top) ? 8'h00 : idx_o + 8'h01;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // pulses are long enough to survive the pin synchroniser; idle low
  assign crank_o = run_i && cnt_q < 16'h0004;
  assign cam_o   = run_i && idx_o == 8'h01 && cnt_q >= 16'h0008 && cnt_q < 16'h0010;
endmodule
`default_nettype wire

// ===== bench/eat_tracker_bench.sv
`timescale 1ns/100ps
`default_nettype none
module eat_tracker_bench;
  import eat_pkg::*;
  localparam int P   = 256;         // tooth spacing in cycles
  localparam int K   = 6;           // wheel teeth
  localparam int REV = (K + 1) * P; // longest turn
  logic clk, arst_n, ce, hsel, hwrite, hready, hresp, pulse, irq, cam, crank, run, extra;
  logic [7:0]  haddr, idx;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd, wv;
  int          error_cnt, n_compared, cyc, cams, n;
  bit          rnd_ce;
  logic [7:0]  ra [11] = '{OFS_CTRL, OFS_RATIO, OFS_TEETH, OFS_LIMIT, OFS_CAMCNT, OFS_RISE,
                           OFS_FALL, OFS_DELAY, OFS_STATUS, OFS_BANK, 8'h30};
  logic [31:0] rv [11] = '{32'h0, 32'h0180, 32'h003A, 32'h003A, 32'h1, 32'h0, 32'h0, 32'h1,
                           32'h0, 32'h0, 32'h0};
  logic [7:0]  ma [5] = '{OFS_RISE, OFS_FALL, OFS_DELAY, OFS_BANK, 8'h34};
  eat_tracker eat_tracker_i (.core_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .cam_pin_i(cam),
    .crank_pin_i(crank), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pulse_o(pulse), .irq_o(irq));
  eat_wheel_model eat_wheel_model_i (.core_clk_i(clk), .arst_n_i(arst_n), .run_i(run),
    .extra_i(extra), .teeth_i(8'(K)), .per_i(16'(P)), .cam_o(cam), .crank_o(crank),
    .idx_o(idx));
  // ****
  // clock, timeout, stalls
  // ****
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      complete_run();
    end
  end
  // random bus stalls only while the wheel stands, or teeth would be lost
  always @(posedge clk) ce <= rnd_ce ? ($urandom_range(7) != 0) : 1'b1;
  always @(posedge cam) cams++;
  // ****
  // tasks
  // ****
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic mid(input int i);
    while (idx === 8'(i)) @(posedge clk);
    while (idx !== 8'(i)) @(posedge clk);
    repeat (P / 2) @(posedge clk);
  endtask
  function automatic logic [31:0] rmask(input logic [7:0] a);
    if (a == OFS_RISE || a == OFS_FALL) return 32'h0000_FFFF;
    if (a == OFS_DELAY) return 32'h00FF_FFFF;
    return 32'h0000_0000; // read-only or unmapped
  endfunction
  function automatic logic [31:0] nreg(input logic ex);
    return ex ? 32'(K) : 32'(K - 1); // regular teeth per turn
  endfunction
  // mid-tooth snapshot: tooth index, fraction, period, bank, status
  task automatic track(input int i);
    mid(i);
    ahb(0, OFS_ANGLE, 0);
    chk(32'(rd[15:8]), 32'(i));
    chk(32'(rd[7:0] > 8'd100 && rd[7:0] < 8'd180), 32'h1);
    ahb(0, OFS_PERIOD, 0);
    chk(rd, 32'(P));
    ahb(0, OFS_BANK, 0);
    chk(rd, 32'(cams));
    ahb(0, OFS_STATUS, 0);
    chk(32'(rd[3:0]), 32'hC);
    chk(32'(irq), 32'h0);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    clk = 0; arst_n = 0; ce = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    run = 0; extra = 0; rnd_ce = 0; error_cnt = 0; n_compared = 0; cyc = 0; cams = 0;
    void'($urandom(45));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rnd_ce = 1;
    for (int i = 0; i < 11; i++) begin
      ahb(0, ra[i], 0);
      chk(rd, rv[i]);
    end
    for (int i = 0; i < 10; i++) begin
      wv = $urandom;
      n = $urandom_range(4);
      ahb(1, ma[n], $urandom);
      ahb(1, ma[n], wv);
      ahb(0, ma[n], 0);
      chk(rd, wv & rmask(ma[n]));
    end
    rnd_ce = 0;
    $display("registers done");
    ahb(1, OFS_TEETH, nreg(0));
    ahb(1, OFS_LIMIT, nreg(0));
    ahb(1, OFS_CTRL, 32'h1);
    run <= 1'b1;
    repeat (2 * REV) @(posedge clk);
    ahb(1, OFS_STATUS, 32'h3);
    track(2);
    $display("gap wheel done");
    ahb(1, OFS_RATIO, 32'h0300);
    repeat (2 * REV) @(posedge clk);
    ahb(0, OFS_STATUS, 0);
    chk(32'(rd[1]), 32'h1);
    chk(32'(irq), 32'h1);
    ahb(1, OFS_RATIO, 32'h0180);
    repeat (2 * REV) @(posedge clk);
    ahb(1, OFS_STATUS, 32'h3);
    repeat (REV) @(posedge clk);
    ahb(0, OFS_STATUS, 0);
    chk(32'(rd[1:0]), 32'h0);
    ahb(1, OFS_TEETH, nreg(1));
    repeat (2 * REV) @(posedge clk);
    ahb(0, OFS_STATUS, 0);
    chk(32'(rd[0]), 32'h1);
    run <= 1'b0;
    ahb(1, OFS_STATUS, 32'h3);
    ahb(0, OFS_STATUS, 0);
    chk(32'(rd[1:0]), 32'h0);
    chk(32'(irq), 32'h0);
    $display("errors done");
    extra <= 1'b1;
    ahb(1, OFS_CTRL, 32'h3);
    ahb(1, OFS_RATIO, 32'h00C0);
    ahb(1, OFS_LIMIT, nreg(1));
    run <= 1'b1;
    repeat (2 * REV) @(posedge clk);
    ahb(1, OFS_STATUS, 32'h3);
    track(3);
    $display("extra wheel done");
    ahb(1, OFS_RISE, 32'h0300);
    ahb(1, OFS_FALL, 32'h0500);
    ahb(1, OFS_CTRL, 32'h7);
    mid(2);
    mid(4);
    chk(32'(pulse), 32'h1);
    mid(5);
    chk(32'(pulse), 32'h0);
    ahb(1, OFS_DELAY, 32'd100);
    ahb(1, OFS_CTRL, 32'hF);
    while (pulse !== 1'b1) @(posedge clk);
    n = 0;
    while (pulse === 1'b1) begin
      n++;
      @(posedge clk);
    end
    chk(32'(n >= 99 && n <= 101), 32'h1);
    ahb(1, OFS_CTRL, 32'h3);
    $display("pulse done");
    complete_run();
  end
endmodule
`default_nettype wire
